// file: stc_chk_props.sv
// Port-level checker for the serial transparent channel
`timescale 1ns/10ps
module stc_chk_props
	import stc_pkg::*;
(
	input wire logic              sys_clk_in,
	input wire logic              rst_in,
	input wire logic [ADDR_W-1:0] avs_address_in,
	input wire logic              avs_read_in,
	input wire logic              avs_write_in,
	input wire logic [31:0]       avs_writedata_in,
	input wire logic [3:0]        avs_byteenable_in,
	input wire logic [31:0]       avs_readdata_out,
	input wire logic              avs_waitrequest_out,
	input wire logic              ser_txd_out,
	input wire logic              irq_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	logic req;
	// Either strobe counts as a request
	assign req = avs_read_in | avs_write_in;
	sequence s_wait; req && avs_waitrequest_out; endsequence
	sequence s_done; req && !avs_waitrequest_out; endsequence
	property p_ans; s_wait |=> s_done; endproperty
	property p_first; s_done |=> !req || avs_waitrequest_out; endproperty
	property p_idle; !req |-> !avs_waitrequest_out; endproperty
	property p_ev_rsv;
		s_done ##0 avs_read_in && avs_address_in == OFF_EVENT
		|-> (avs_readdata_out & ~{24'h000000, EV_IMPL}) == 32'h00000000;
	endproperty
	property p_cmd; s_done ##0 avs_read_in && avs_address_in == OFF_CMD
		|-> avs_readdata_out == 32'h00000000; endproperty
	property p_unmap; s_done ##0 avs_read_in && avs_address_in == 10'h3F0
		|-> avs_readdata_out == 32'h00000000; endproperty
	property p_buf_hi; s_done ##0 avs_read_in && avs_address_in[9:8] == 2'h1
		|-> avs_readdata_out[31:8] == 24'h000000; endproperty
	property p_stand; !avs_read_in [*2] |-> $stable(avs_readdata_out); endproperty
	property p_mask; s_done ##0 avs_write_in && avs_address_in == OFF_MASK
		&& avs_byteenable_in[0] && avs_writedata_in[7:0] == 8'h00 |=> !irq_out; endproperty
	property p_rst_out; $fell(rst_in) |-> ser_txd_out && !irq_out; endproperty
	a_ans: assert property (p_ans) else $error("access not answered in its second cycle");
	a_first: assert property (p_first) else $error("no wait state on a new access");
	a_idle: assert property (p_idle) else $error("waitrequest high while idle");
	a_ev_rsv: assert property (p_ev_rsv) else $error("reserved event bit reads one");
	a_cmd: assert property (p_cmd) else $error("command register reads nonzero");
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	a_buf_hi: assert property (p_buf_hi) else $error("receive byte upper bits set");
	a_stand: assert property (p_stand) else $error("read data moved without a read");
	a_mask: assert property (p_mask) else $error("irq with all events masked");
	a_rst_out: assert property (p_rst_out) else $error("outputs wrong after reset");
endmodule
bind stc_serial_transparent_channel stc_chk_props i_chk (
	.sys_clk_in(sys_clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
	.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
	.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
	.ser_txd_out(ser_txd_out), .irq_out(irq_out));

// file: stc_line_peer.sv
// Serial line peer: frames clock, sync and receive data, captures transmit data
`timescale 1ns/10ps
module stc_line_peer (
	output logic      sclk_out,
	output logic      sync_n_out,
	output logic      rxd_out,
	input  wire logic txd_in
);
	// Clock stands high outside frames
	initial begin
		sclk_out = 1'b1;
		sync_n_out = 1'b1;
		rxd_out = 1'b1;
	end
	// One frame: sync fall, then n bits sent first-to-last, txd taken mid high phase
	task automatic frame(input logic [15:0] bits, input int n, output logic [15:0] got);
		got = 16'h0000;
		#13;
		sync_n_out = 1'b0;
		#400;
		for (int i = 0; i < n; i++) begin
			sclk_out = 1'b0;
			rxd_out = bits[i];
			#200;
			sclk_out = 1'b1;
			#100;
			got[i] = txd_in;
			#100;
		end
		sync_n_out = 1'b1;
		// Released line shows no stale bit
		rxd_out = ~rxd_out;
	endtask
endmodule

// file: stc_pkg.sv
// Shared constants, register map and carrier types of the serial transparent channel
package stc_pkg;
	// Descriptor tables and buffers held in flip-flops
	localparam int BD_NUM    = 2;
	localparam int BUF_BYTES = 16;
	localparam int ADDR_W    = 10;

	// Register byte offsets
	localparam logic [9:0] OFF_MODE   = 10'h000;
	localparam logic [9:0] OFF_EVENT  = 10'h004;
	localparam logic [9:0] OFF_MASK   = 10'h008;
	localparam logic [9:0] OFF_MAXRX  = 10'h00C;
	localparam logic [9:0] OFF_CMD    = 10'h010;
	localparam logic [9:0] OFF_RXBD   = 10'h020;
	localparam logic [9:0] OFF_TXBD   = 10'h030;
	localparam logic [9:0] OFF_RXDATA = 10'h100;
	localparam logic [9:0] OFF_TXDATA = 10'h200;

	// Mode register fields
	localparam int MODE_REN   = 0;
	localparam int MODE_TEN   = 1;
	localparam int MODE_DM    = 2;
	localparam int MODE_SM    = 4;
	localparam int MODE_MSB_FIRST_SELECT  = 8;
	localparam int MODE_CHAR_WIDTH_FIELD  = 11;
	localparam logic [15:0] MODE_RESET = 16'h0000;
	localparam logic [15:0] MODE_WMASK = 16'h793F;

	localparam logic [1:0] SM_TRANSPARENT = 2'h3;
	localparam logic [1:0] DM_NORMAL      = 2'h0;
	localparam logic [1:0] DM_LOOP        = 2'h1;
	localparam logic [1:0] DM_ECHO        = 2'h2;
	localparam logic [3:0] CHAR_WIDTH_FIELD_BYTE_MAX  = 4'h7;

	// Event register bits
	localparam int EV_RX  = 0;
	localparam int EV_TX  = 1;
	localparam int EV_BSY = 2;
	localparam int EV_TXE = 4;
	localparam logic [7:0] EV_IMPL  = 8'h17;
	localparam logic [7:0] EV_RESET = 8'h00;

	// Command register bits
	localparam int CMD_HUNT    = 0;
	localparam int CMD_RESTART = 1;

	// Descriptor word fields (status in upper half, length in lower)
	localparam int BD_OWN  = 31;
	localparam int BD_WRAP = 29;
	localparam int BD_INTR = 28;
	localparam int BD_LAST = 27;
	localparam int BD_CONT = 25;
	localparam int BD_ERR  = 17;
	localparam logic [7:0] MAXRX_RESET = 8'h10;

	typedef struct packed {
		logic       own;
		logic       wrap;
		logic       intr;
		logic       last;
		logic       cont;
		logic       err;
		logic [7:0] len;
	} stc_bd_type;

	typedef struct packed {
		logic sclk;
		logic sync_n;
		logic rxd;
	} stc_pins_type;
endpackage

// file: stc_serial_transparent_channel.sv
// Transparent serial channel: registers, descriptor tables, buffers and serial engine
// Contract
// - Width field 3..15 gives characters of field plus one bits.
// - Narrow characters use one byte; upper bits ignored on send, zero on receive.
// - Characters above 8 bits use one word; upper bits ignored or zeroed.
// - Reverse-data bit set shifts most significant bit first.
// - Protocol select 11 alone enables transparent behaviour.
// - Diagnostic field: 00 normal, 01 local loopback, 10 echo, 11 reserved.
// - Overrun, full buffer or hunt closes buffer, raises event, moves on.
// - Receive empty flag hands buffer over; cleared on fill or error.
// - Wrap flag marks last descriptor; controller returns to table start.
// - Receive interrupt flag set raises receive-buffer event when buffer fills.
// - Receive continuous mode keeps empty flag; error still clears it.
// - Ready flag hands transmit buffer over; cleared after send or error.
// - Transmit interrupt flag raises transmit or transmit-error event.
// - Last flag clear chains next buffer; set forces resynchronisation.
// - Transmit continuous mode keeps ready flag; error still clears it.
// - Transmit length counts octets and is never modified.
// - Underrun sets descriptor underrun flag and transmit-error event.
// - Event register readable, write one clears, resets to zero.
// - Interrupt request stays while any unmasked event bit is set.
// - Mask bits enable matching events; mask resets to zero.
// - Character without empty buffer is discarded and sets busy event.
//
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/10ps
module stc_serial_transparent_channel
	import stc_pkg::*;
(
	input  wire logic              sys_clk_in,
	input  wire logic              rst_in,
	input  wire logic [ADDR_W-1:0] avs_address_in,
	input  wire logic              avs_read_in,
	input  wire logic              avs_write_in,
	input  wire logic [31:0]       avs_writedata_in,
	input  wire logic [3:0]        avs_byteenable_in,
	output logic [31:0]            avs_readdata_out,
	output logic                   avs_waitrequest_out,
	input  wire logic              ser_clk_in,
	input  wire logic              ser_sync_n_in,
	input  wire logic              ser_rxd_in,
	output logic                   ser_txd_out,
	output logic                   irq_out
);
	typedef enum logic [1:0] {TX_IDLE, TX_WAIT_SYNC, TX_SEND, TX_HALT} stc_tx_state_type;

	// Mask of the valid character bits for a width field value;
	// a field of 15 keeps all sixteen bits
	function automatic logic [15:0] char_mask(input logic [3:0] char_width_field);
		char_mask = 16'hFFFF >> (4'hF - char_width_field);
	endfunction

	// Next descriptor index honouring the wrap flag and table end
	function automatic logic next_idx(input logic idx, input logic wrap);
		next_idx = (wrap || idx == 1'(BD_NUM - 1)) ? 1'b0 : ~idx;
	endfunction

	stc_pins_type     pin_meta_q, pin_sync_q, pin_prev_q;
	logic             ack_q, ack_d;
	logic [31:0]      rdata_q, rdata_d;
	logic [15:0]      mode_q, mode_d;
	logic [7:0]       ev_q, ev_d, mask_q, mask_d, maxrx_q, maxrx_d;
	stc_bd_type       rxbd_q [BD_NUM];
	stc_bd_type       rxbd_d [BD_NUM];
	stc_bd_type       txbd_q [BD_NUM];
	stc_bd_type       txbd_d [BD_NUM];
	logic [7:0]       rxmem_q [BD_NUM*BUF_BYTES];
	logic [7:0]       rxmem_d [BD_NUM*BUF_BYTES];
	logic [7:0]       txmem_q [BD_NUM*BUF_BYTES];
	logic [7:0]       txmem_d [BD_NUM*BUF_BYTES];
	logic             rx_sync_q, rx_sync_d, rx_idx_q, rx_idx_d;
	logic [15:0]      rx_sh_q, rx_sh_d;
	logic [4:0]       rx_bits_q, rx_bits_d;
	logic [7:0]       rx_cnt_q, rx_cnt_d;
	stc_tx_state_type tx_st_q, tx_st_d;
	logic             tx_idx_q, tx_idx_d, txd_q, txd_d;
	logic [15:0]      tx_sh_q, tx_sh_d;
	logic [4:0]       tx_bits_q, tx_bits_d;
	logic [7:0]       tx_pos_q, tx_pos_d;

	// Pin synchroniser; edges are found only on the second stage
	// Reset to the pins' idle levels, so no false edge follows reset
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pin_meta_q <= '1;
			pin_sync_q <= '1;
			pin_prev_q <= '1;
		end else begin
			pin_meta_q <= '{sclk: ser_clk_in, sync_n: ser_sync_n_in, rxd: ser_rxd_in};
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
		end
	end

	logic        sclk_rise, sclk_fall, sync_fall, transparent, rx_bit, wide;
	logic [3:0]  char_width_field;
	logic [4:0]  nbits;
	logic [15:0] cmask;
	logic [7:0]  rx_limit;
	logic [9:0]  woff;
	logic        bus_wr, bus_rd;

	// Decoded mode and serial events
	// Loopback feeds the receiver from the transmit register, not the pin
	always_comb begin
		sclk_rise   = pin_sync_q.sclk & ~pin_prev_q.sclk;
		sclk_fall   = ~pin_sync_q.sclk & pin_prev_q.sclk;
		sync_fall   = ~pin_sync_q.sync_n & pin_prev_q.sync_n;
		transparent = mode_q[MODE_SM +: 2] == SM_TRANSPARENT;
		char_width_field        = mode_q[MODE_CHAR_WIDTH_FIELD +: 4];
		nbits       = {1'b0, char_width_field} + 5'h01;
		cmask       = char_mask(char_width_field);
		wide        = char_width_field > CHAR_WIDTH_FIELD_BYTE_MAX;
		rx_bit      = (mode_q[MODE_DM +: 2] == DM_LOOP) ? txd_q : pin_sync_q.rxd;
		rx_limit    = (maxrx_q > 8'(BUF_BYTES)) ? 8'(BUF_BYTES) : maxrx_q;
		bus_wr      = avs_write_in & ack_q;
		bus_rd      = avs_read_in & ~ack_q;
		woff        = avs_address_in - OFF_RXDATA;
	end

	// Avalon slave: one wait cycle on every access
	// The wait cycle gives the registered read data time to settle
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
	assign avs_readdata_out    = rdata_q;
	assign irq_out             = |(ev_q & mask_q);
	assign ser_txd_out         = (mode_q[MODE_DM +: 2] == DM_ECHO) ? pin_sync_q.rxd : txd_q;

	logic rx_close, rx_err, tx_close, tx_err, hunt, restart;

	// Next state of registers, descriptors, buffers and both serial engines
	always_comb begin
		mode_d = mode_q;   ev_d = ev_q;   mask_d = mask_q;   maxrx_d = maxrx_q;
		rxbd_d = rxbd_q;   txbd_d = txbd_q;   rxmem_d = rxmem_q;   txmem_d = txmem_q;
		rx_sync_d = rx_sync_q;   rx_idx_d = rx_idx_q;   rx_sh_d = rx_sh_q;
		rx_bits_d = rx_bits_q;   rx_cnt_d = rx_cnt_q;
		tx_st_d = tx_st_q;   tx_idx_d = tx_idx_q;   txd_d = txd_q;
		tx_sh_d = tx_sh_q;   tx_bits_d = tx_bits_q;   tx_pos_d = tx_pos_q;
		rx_close = 1'b0;   rx_err = 1'b0;   tx_close = 1'b0;   tx_err = 1'b0;
		hunt = 1'b0;   restart = 1'b0;
		ack_d = (avs_read_in | avs_write_in) & ~ack_q;
		rdata_d = rdata_q;

		// Register reads; unmapped addresses read zero
		// Descriptor words: status flags in bits 31:16, length in bits 7:0
		if (bus_rd) begin
			rdata_d = 32'h0000_0000;
			if (avs_address_in == OFF_MODE)  rdata_d = {16'h0000, mode_q};
			if (avs_address_in == OFF_EVENT) rdata_d = {24'h000000, ev_q};
			if (avs_address_in == OFF_MASK)  rdata_d = {24'h000000, mask_q};
			if (avs_address_in == OFF_MAXRX) rdata_d = {24'h000000, maxrx_q};
			for (int i = 0; i < BD_NUM; i++) begin
				if (avs_address_in == OFF_RXBD + 10'(4 * i))
					rdata_d = {rxbd_q[i].own, 1'b0, rxbd_q[i].wrap, rxbd_q[i].intr, 2'h0,
						rxbd_q[i].cont, 7'h00, rxbd_q[i].err, 1'b0, 8'h00, rxbd_q[i].len};
				if (avs_address_in == OFF_TXBD + 10'(4 * i))
					rdata_d = {txbd_q[i].own, 1'b0, txbd_q[i].wrap, txbd_q[i].intr,
						txbd_q[i].last, 1'b0, txbd_q[i].cont, 7'h00, txbd_q[i].err, 1'b0,
						8'h00, txbd_q[i].len};
			end
			if (avs_address_in >= OFF_RXDATA && avs_address_in < OFF_RXDATA + 10'h080)
				rdata_d = {24'h000000, rxmem_q[woff[6:2]]};
			if (avs_address_in >= OFF_TXDATA && avs_address_in < OFF_TXDATA + 10'h080)
				rdata_d = {24'h000000, txmem_q[woff[6:2]]};
		end

		// Register writes, taken at the edge where waitrequest is low
		if (bus_wr) begin
			if (avs_address_in == OFF_MODE) begin
				if (avs_byteenable_in[0]) mode_d[7:0]  = avs_writedata_in[7:0] & MODE_WMASK[7:0];
				if (avs_byteenable_in[1]) mode_d[15:8] = avs_writedata_in[15:8] & MODE_WMASK[15:8];
			end
			if (avs_address_in == OFF_EVENT && avs_byteenable_in[0])
				ev_d = ev_q & ~avs_writedata_in[7:0];
			if (avs_address_in == OFF_MASK && avs_byteenable_in[0])
				mask_d = avs_writedata_in[7:0] & EV_IMPL;
			if (avs_address_in == OFF_MAXRX && avs_byteenable_in[0])
				maxrx_d = avs_writedata_in[7:0];
			if (avs_address_in == OFF_CMD && avs_byteenable_in[0]) begin
				hunt    = avs_writedata_in[CMD_HUNT];
				restart = avs_writedata_in[CMD_RESTART];
			end
			for (int i = 0; i < BD_NUM; i++) begin
				if (avs_address_in == OFF_RXBD + 10'(4 * i))
					rxbd_d[i] = '{own: avs_writedata_in[BD_OWN], wrap: avs_writedata_in[BD_WRAP],
						intr: avs_writedata_in[BD_INTR], last: 1'b0,
						cont: avs_writedata_in[BD_CONT], err: avs_writedata_in[BD_ERR],
						len: avs_writedata_in[7:0]};
				if (avs_address_in == OFF_TXBD + 10'(4 * i))
					txbd_d[i] = '{own: avs_writedata_in[BD_OWN], wrap: avs_writedata_in[BD_WRAP],
						intr: avs_writedata_in[BD_INTR], last: avs_writedata_in[BD_LAST],
						cont: avs_writedata_in[BD_CONT], err: avs_writedata_in[BD_ERR],
						len: avs_writedata_in[7:0]};
			end
			if (avs_address_in >= OFF_RXDATA && avs_address_in < OFF_RXDATA + 10'h080)
				rxmem_d[woff[6:2]] = avs_writedata_in[7:0];
			if (avs_address_in >= OFF_TXDATA && avs_address_in < OFF_TXDATA + 10'h080)
				txmem_d[woff[6:2]] = avs_writedata_in[7:0];
		end

		// Receiver: sync on falling sync pin, sample on rising serial clock
		if (!mode_q[MODE_REN] || !transparent) begin
			rx_sync_d = 1'b0;
			rx_bits_d = 5'h00;
		end else if (hunt) begin
			rx_sync_d = 1'b0;
			rx_bits_d = 5'h00;
			rx_close  = rx_cnt_q != 8'h00;
		end else if (!rx_sync_q) begin
			rx_sync_d = sync_fall;
		end else if (sclk_rise) begin
			// Bit order per reverse-data; LSB-first fills from the top down
			if (mode_q[MODE_MSB_FIRST_SELECT])
				rx_sh_d = {rx_sh_q[14:0], rx_bit};
			else begin
				rx_sh_d = {1'b0, rx_sh_q[15:1]};
				rx_sh_d[char_width_field] = rx_bit;
			end
			rx_bits_d = rx_bits_q + 5'h01;
			if (rx_bits_q + 5'h01 == nbits) begin
				rx_bits_d = 5'h00;
				rx_sh_d   = rx_sh_d & cmask;
				// No empty buffer: the character is dropped and busy is flagged
				if (!rxbd_q[rx_idx_q].own) begin
					ev_d[EV_BSY] = 1'b1;
				end else begin
					// Store character; upper bits already zero
					rxmem_d[{rx_idx_q, rx_cnt_q[3:0]}] = rx_sh_d[7:0];
					if (wide)
						rxmem_d[{rx_idx_q, rx_cnt_q[3:0] + 4'h1}] = rx_sh_d[15:8];
					rx_cnt_d = rx_cnt_q + (wide ? 8'h02 : 8'h01);
					rx_close = rx_cnt_d >= rx_limit;
				end
			end
		end

		// Close the receive buffer: length, ownership, event, advance
		// The error input is kept for overrun, which flop buffers never see
		if (rx_close) begin
			rxbd_d[rx_idx_q].len = rx_cnt_d;
			rxbd_d[rx_idx_q].err = rx_err;
			if (!rxbd_q[rx_idx_q].cont || rx_err)
				rxbd_d[rx_idx_q].own = 1'b0;
			if (rxbd_q[rx_idx_q].intr)
				ev_d[EV_RX] = 1'b1;
			rx_idx_d = next_idx(rx_idx_q, rxbd_q[rx_idx_q].wrap);
			rx_cnt_d = 8'h00;
		end

		// Transmitter state machine; idles are ones, but an idle state turns
		// the line to one only at a falling serial clock, so the last data bit
		// keeps its whole bit time
		unique case (tx_st_q)
			TX_IDLE: begin
				if (sclk_fall)
					txd_d = 1'b1;
				if (mode_q[MODE_TEN] && transparent && txbd_q[tx_idx_q].own)
					tx_st_d = TX_WAIT_SYNC;
			end
			TX_WAIT_SYNC: begin
				if (sclk_fall)
					txd_d = 1'b1;
				if (sync_fall) begin
					tx_st_d  = TX_SEND;
					tx_pos_d = 8'h00;
					tx_bits_d = 5'h00;
				end
			end
			TX_SEND: begin
				if (sclk_fall) begin
					// Fetch a character at each character boundary
					if (tx_bits_q == 5'h00) begin
						tx_sh_d = {txmem_q[{tx_idx_q, tx_pos_q[3:0] + 4'h1}],
							txmem_q[{tx_idx_q, tx_pos_q[3:0]}]};
						if (!wide)
							tx_sh_d[15:8] = 8'h00;
						tx_sh_d   = tx_sh_d & cmask;
						tx_pos_d  = tx_pos_q + (wide ? 8'h02 : 8'h01);
						tx_bits_d = nbits;
					end else begin
						tx_sh_d = tx_sh_q;
					end
					txd_d = mode_q[MODE_MSB_FIRST_SELECT] ? tx_sh_d[char_width_field] : tx_sh_d[0];
					tx_sh_d = mode_q[MODE_MSB_FIRST_SELECT] ? {tx_sh_d[14:0], 1'b0} : {1'b0, tx_sh_d[15:1]};
					tx_bits_d = tx_bits_d - 5'h01;
					if (tx_bits_d == 5'h00 && tx_pos_d >= txbd_q[tx_idx_q].len) begin
						tx_close = 1'b1;
						tx_idx_d = next_idx(tx_idx_q, txbd_q[tx_idx_q].wrap);
						tx_pos_d = 8'h00;
						if (txbd_q[tx_idx_q].last)
							tx_st_d = TX_IDLE;
						else if (!txbd_q[tx_idx_d].own || tx_idx_d == tx_idx_q) begin
							tx_err  = !(txbd_q[tx_idx_q].cont && tx_idx_d == tx_idx_q);
							tx_st_d = tx_err ? TX_HALT : TX_SEND;
						end
					end
				end
			end
			TX_HALT: begin
				if (sclk_fall)
					txd_d = 1'b1;
				if (restart)
					tx_st_d = TX_IDLE;
			end
		endcase
		if (!mode_q[MODE_TEN]) begin
			tx_st_d = TX_IDLE;
			txd_d   = 1'b1;
		end

		// Close the transmit buffer; underrun wins over normal completion
		// Underrun raises the error event whatever the interrupt flag says
		if (tx_close) begin
			txbd_d[tx_idx_q].err = tx_err;
			if (!txbd_q[tx_idx_q].cont || tx_err)
				txbd_d[tx_idx_q].own = 1'b0;
			if (tx_err)
				ev_d[EV_TXE] = 1'b1;
			else if (txbd_q[tx_idx_q].intr)
				ev_d[EV_TX] = 1'b1;
		end
	end

	// Register all state
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ack_q     <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			mode_q    <= MODE_RESET;
			ev_q      <= EV_RESET;
			mask_q    <= EV_RESET;
			maxrx_q   <= MAXRX_RESET;
			rxbd_q    <= '{default: '0};
			txbd_q    <= '{default: '0};
			rxmem_q   <= '{default: 8'h00};
			txmem_q   <= '{default: 8'h00};
			rx_sync_q <= 1'b0;
			rx_idx_q  <= 1'b0;
			rx_sh_q   <= 16'h0000;
			rx_bits_q <= 5'h00;
			rx_cnt_q  <= 8'h00;
			tx_st_q   <= TX_IDLE;
			tx_idx_q  <= 1'b0;
			txd_q     <= 1'b1;
			tx_sh_q   <= 16'h0000;
			tx_bits_q <= 5'h00;
			tx_pos_q  <= 8'h00;
		end else begin
			ack_q     <= ack_d;
			rdata_q   <= rdata_d;
			mode_q    <= mode_d;
			ev_q      <= ev_d;
			mask_q    <= mask_d;
			maxrx_q   <= maxrx_d;
			rxbd_q    <= rxbd_d;
			txbd_q    <= txbd_d;
			rxmem_q   <= rxmem_d;
			txmem_q   <= txmem_d;
			rx_sync_q <= rx_sync_d;
			rx_idx_q  <= rx_idx_d;
			rx_sh_q   <= rx_sh_d;
			rx_bits_q <= rx_bits_d;
			rx_cnt_q  <= rx_cnt_d;
			tx_st_q   <= tx_st_d;
			tx_idx_q  <= tx_idx_d;
			txd_q     <= txd_d;
			tx_sh_q   <= tx_sh_d;
			tx_bits_q <= tx_bits_d;
			tx_pos_q  <= tx_pos_d;
		end
	end
endmodule

// file: stc_serial_transparent_channel_tb_top.sv
// Self-checking bench for the serial transparent channel
`timescale 1ns/10ps
module stc_serial_transparent_channel_tb_top;
	import stc_pkg::*;
	typedef struct packed {
		logic        wr;
		logic [9:0]  addr;
		logic [31:0] wdata;
		logic [31:0] exp;
	} stc_row_type;
	logic        sys_clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic [9:0]  avs_address_in = 10'h000;
	logic        avs_read_in = 1'b0;
	logic        avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h00000000;
	logic [31:0] avs_readdata_out;
	logic        avs_waitrequest_out;
	logic        sclk, sync_n, rxd, ser_txd_out, irq_out;
	logic [31:0] d;
	logic [15:0] got;
	int          n_errors = 0;
	int          checked = 0;
	stc_row_type rows [14] = '{
		'{1'b0, OFF_MODE, 32'h0, 32'h0}, '{1'b0, OFF_EVENT, 32'h0, 32'h0},
		'{1'b0, OFF_MASK, 32'h0, 32'h0}, '{1'b0, OFF_MAXRX, 32'h0, 32'h10},
		'{1'b0, OFF_CMD, 32'h0, 32'h0}, '{1'b1, OFF_MODE, 32'hFFFFFFFF, 32'h0},
		'{1'b0, OFF_MODE, 32'h0, 32'h793F}, '{1'b1, OFF_MODE, 32'h0, 32'h0},
		'{1'b1, OFF_MASK, 32'h17, 32'h0}, '{1'b0, OFF_MASK, 32'h0, 32'h17},
		'{1'b1, 10'h3F0, 32'hFFFFFFFF, 32'h0}, '{1'b0, 10'h3F0, 32'h0, 32'h0},
		'{1'b1, OFF_EVENT, 32'hFF, 32'h0}, '{1'b0, OFF_EVENT, 32'h0, 32'h0}};
	// Half period of the 20 MHz clock
	always #25 sys_clk_in = ~sys_clk_in;
	stc_serial_transparent_channel i_dut (
		.sys_clk_in(sys_clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hF),
		.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
		.ser_clk_in(sclk), .ser_sync_n_in(sync_n), .ser_rxd_in(rxd),
		.ser_txd_out(ser_txd_out), .irq_out(irq_out));
	stc_line_peer i_peer (.sclk_out(sclk), .sync_n_out(sync_n), .rxd_out(rxd),
		.txd_in(ser_txd_out));
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One Avalon access; waitrequest and read data are taken at the same rising edge,
	// before that edge's own updates land; one idle edge follows each access
	task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		avs_address_in <= a;
		avs_writedata_in <= wd;
		avs_write_in <= w;
		avs_read_in <= !w;
		do begin
			@(posedge sys_clk_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 20);
		d = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
		if (n >= 20) begin
			n_errors++;
			tally_and_finish();
		end
		@(posedge sys_clk_in);
	endtask
	task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(d, exp);
	endtask
	task automatic settle();
		repeat (10) @(posedge sys_clk_in);
	endtask
	initial begin
		repeat (8) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		@(posedge sys_clk_in);
		foreach (rows[i]) begin
			bus(rows[i].wr, rows[i].addr, rows[i].wdata);
			if (!rows[i].wr) chk(d, rows[i].exp);
		end
		// Two 8-bit characters fill a two-byte buffer
		bus(1'b1, OFF_MAXRX, 32'h2);
		bus(1'b1, OFF_RXBD, 32'h90000000);
		bus(1'b1, OFF_RXBD + 10'h4, 32'hB0000000);
		bus(1'b1, OFF_MASK, 32'h1);
		bus(1'b1, OFF_MODE, 32'h3831);
		i_peer.frame(16'h3CA5, 16, got);
		settle();
		rd_chk(OFF_RXDATA, 32'hA5);
		rd_chk(OFF_RXDATA + 10'h4, 32'h3C);
		rd_chk(OFF_RXBD, 32'h10000002);
		chk(irq_out, 1'b1);
		rd_chk(OFF_EVENT, 32'h1);
		bus(1'b1, OFF_EVENT, 32'h1);
		chk(irq_out, 1'b0);
		// Five-bit characters, most significant bit first, into the wrap descriptor
		bus(1'b1, OFF_MODE, 32'h2130);
		bus(1'b1, OFF_MODE, 32'h2131);
		i_peer.frame(16'h028B, 10, got);
		settle();
		rd_chk(OFF_RXDATA + 10'h40, 32'h1A);
		rd_chk(OFF_RXDATA + 10'h44, 32'h05);
		rd_chk(OFF_RXBD + 10'h4, 32'h30000002);
		// Back at the first descriptor, now owned by software
		i_peer.frame(16'h0015, 5, got);
		settle();
		bus(1'b0, OFF_EVENT, 32'h0);
		chk(d[EV_BSY], 1'b1);
		bus(1'b1, OFF_MODE, 32'h0);
		// Nine-bit character into a continuous descriptor: word storage, flag kept
		bus(1'b1, OFF_RXBD, 32'h82000000);
		bus(1'b1, OFF_MODE, 32'h4031);
		i_peer.frame(16'h01A5, 9, got);
		settle();
		rd_chk(OFF_RXDATA, 32'hA5);
		rd_chk(OFF_RXDATA + 10'h4, 32'h01);
		rd_chk(OFF_RXBD, 32'h82000002);
		// Hunt closes a part-filled buffer
		bus(1'b1, OFF_RXBD + 10'h4, 32'hB0000000);
		bus(1'b1, OFF_MODE, 32'h3831);
		i_peer.frame(16'h0096, 8, got);
		settle();
		bus(1'b1, OFF_CMD, 32'h1);
		rd_chk(OFF_RXBD + 10'h4, 32'h30000001);
		rd_chk(OFF_RXDATA + 10'h40, 32'h96);
		bus(1'b1, OFF_MODE, 32'h0);
		bus(1'b1, OFF_EVENT, 32'hFF);
		rd_chk(OFF_EVENT, 32'h0);
		// Transmit one byte with the last flag, then a chained byte that runs dry
		bus(1'b1, OFF_TXDATA, 32'h5A);
		bus(1'b1, OFF_TXDATA + 10'h40, 32'hC3);
		bus(1'b1, OFF_TXBD, 32'h98000001);
		bus(1'b1, OFF_MODE, 32'h3832);
		i_peer.frame(16'h0, 12, got);
		settle();
		chk(got[7:0], 8'h5A);
		rd_chk(OFF_TXBD, 32'h18000001);
		rd_chk(OFF_EVENT, 32'h2);
		bus(1'b1, OFF_EVENT, 32'hFF);
		bus(1'b1, OFF_TXBD + 10'h4, 32'hB0000001);
		i_peer.frame(16'h0, 12, got);
		settle();
		chk(got[7:0], 8'hC3);
		rd_chk(OFF_TXBD + 10'h4, 32'h30020001);
		bus(1'b0, OFF_EVENT, 32'h0);
		chk(d[EV_TXE], 1'b1);
		// Only unmasked events reach the interrupt line
		bus(1'b1, OFF_MASK, 32'h10);
		chk(irq_out, 1'b1);
		bus(1'b1, OFF_MASK, 32'h0);
		chk(irq_out, 1'b0);
		tally_and_finish();
	end
endmodule
